// File: logic/bxalu_core.sv
// Purpose: Execute slice for subtract, exclusive-OR and nibble swap
// Assumes: Inputs synchronous to clk_sys; one operation at a time
// Notes:   Literal ops finish one edge after acceptance, register ops three
//
// Summary of operation
// [RULE_01] Literal minus accumulator goes to accumulator; carry, half borrow, zero updated.
// [RULE_02] Accumulator XOR literal goes to accumulator; only zero flag updated.
// [RULE_03] File register minus accumulator; carry, half borrow and zero updated.
// [RULE_04] Accumulator XOR file register; only zero flag updated.
// [RULE_05] Nibble swap of file register; no flag changes.
// [RULE_06] Register ops: destination 0 writes accumulator, 1 writes file register.
// [RULE_07] Carry set without borrow from bit 7; half borrow without borrow from bit 3.
`timescale 1ns/1ps
module bxalu_core
    import bxalu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    // Operation request
    input  wire logic              opValid,
    input  wire logic [OP_W-1:0]   opCode,
    input  wire logic [DATA_W-1:0] literal,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic              destSel,
    // Accumulator and file register preload
    input  wire logic              accLoad,
    input  wire logic [DATA_W-1:0] accLoadData,
    input  wire logic              regLoad,
    input  wire logic [ADDR_W-1:0] regLoadAddr,
    input  wire logic [DATA_W-1:0] regLoadData,
    // Results and status
    output logic      [DATA_W-1:0] acc_ff,
    output logic      [DATA_W-1:0] result_ff,
    output logic                   carryFlag_ff,
    output logic                   half_borrow_flag_ff,
    output logic                   zeroFlag_ff,
    output logic                   busy_ff,
    output logic                   done_ff
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Two's complement a - b; returns {no-borrow7, no-borrow3, diff}
    // Set flag bits mean no borrow, so a - a yields both set
    function automatic logic [DATA_W+1:0] subFlags(input logic [DATA_W-1:0] a,
                                                   input logic [DATA_W-1:0] b);
        logic [DATA_W:0] full;
        logic [NIB_W:0]  low;
        full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
        low  = {1'b0, a[NIB_W-1:0]} + {1'b0, ~b[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
        subFlags = {full[DATA_W], low[NIB_W], full[DATA_W-1:0]};  // [RULE_07]
    endfunction

    function automatic logic isRegOp(input logic [OP_W-1:0] op);
        isRegOp = (op == reg_minus_acc_op) || (op == reg_xor_acc_op)
                  || (op == nibble_exchange_op);
    endfunction

    function automatic logic isZero(input logic [DATA_W-1:0] v);
        isZero = (v == DATA_ZERO);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bxalu_state_e      state_ff, nxt_state;
    logic [OP_W-1:0]   op_ff, nxt_op;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic              dest_ff, nxt_dest;
    logic [DATA_W-1:0] nxt_acc, nxt_result;
    logic              nxt_carry, nxt_half, nxt_zero, nxt_busy, nxt_done;
    logic              memWrEn;
    logic [ADDR_W-1:0] memWrAddr;
    logic [DATA_W-1:0] memWrData;
    logic [DATA_W-1:0] fileData;
    logic [DATA_W+1:0] subOut;
    logic [DATA_W-1:0] opResult;

    // ------------------------------------------------------------
    // File register array
    // ------------------------------------------------------------
    // Registered read costs a cycle but maps onto plain block memory
    bxalu_file_mem u_mem (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .wrEn      (memWrEn),
        .wrAddr    (memWrAddr),
        .wrData    (memWrData),
        .rdAddr    (addr_ff),
        .rdData_ff (fileData)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_state  = state_ff;
        nxt_op     = op_ff;
        nxt_addr   = addr_ff;
        nxt_dest   = dest_ff;
        nxt_acc    = acc_ff;
        nxt_result = result_ff;
        nxt_carry  = carryFlag_ff;
        nxt_half   = half_borrow_flag_ff;
        nxt_zero   = zeroFlag_ff;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        memWrEn    = 1'b0;
        memWrAddr  = regLoadAddr;
        memWrData  = regLoadData;
        subOut     = subFlags(literal, acc_ff);
        opResult   = DATA_ZERO;
        case (state_ff)
            BX_IDLE: begin
                // Preloads only while idle, so they never race a writeback
                if (regLoad) begin
                    memWrEn = 1'b1;
                end
                if (accLoad) begin
                    nxt_acc = accLoadData;
                end
                // A literal op overrides a same-cycle accumulator preload
                if (opValid && (opCode == literal_minus_acc_op)) begin
                    nxt_acc    = subOut[DATA_W-1:0];               // [RULE_01]
                    nxt_result = subOut[DATA_W-1:0];
                    nxt_carry  = subOut[DATA_W+1];                 // [RULE_01]
                    nxt_half   = subOut[DATA_W];
                    nxt_zero   = isZero(subOut[DATA_W-1:0]);
                    nxt_done   = 1'b1;
                end else if (opValid && (opCode == literal_xor_acc_op)) begin
                    opResult   = acc_ff ^ literal;                 // [RULE_02]
                    nxt_acc    = opResult;
                    nxt_result = opResult;
                    nxt_zero   = isZero(opResult);                 // [RULE_02]
                    nxt_done   = 1'b1;
                end else if (opValid && isRegOp(opCode)) begin
                    nxt_op    = opCode;
                    nxt_addr  = regAddr;
                    nxt_dest  = destSel;
                    nxt_busy  = 1'b1;
                    nxt_state = BX_FETCH;
                end
            end
            BX_FETCH: begin
                // Memory read register settles on this edge
                nxt_state = BX_EXEC;
            end
            BX_EXEC: begin
                subOut = subFlags(fileData, acc_ff);
                if (op_ff == reg_minus_acc_op) begin
                    opResult  = subOut[DATA_W-1:0];                // [RULE_03]
                    nxt_carry = subOut[DATA_W+1];                  // [RULE_03]
                    nxt_half  = subOut[DATA_W];
                    nxt_zero  = isZero(opResult);
                end else if (op_ff == reg_xor_acc_op) begin
                    opResult  = acc_ff ^ fileData;                 // [RULE_04]
                    nxt_zero  = isZero(opResult);                  // [RULE_04]
                end else begin
                    // Swap leaves every flag as it stood
                    opResult  = {fileData[NIB_W-1:0], fileData[DATA_W-1:NIB_W]}; // [RULE_05]
                end
                if (dest_ff == DEST_REG) begin
                    memWrEn   = 1'b1;                              // [RULE_06]
                    memWrAddr = addr_ff;
                    memWrData = opResult;
                end else begin
                    nxt_acc   = opResult;                          // [RULE_06]
                end
                nxt_result = opResult;
                nxt_done   = 1'b1;
                nxt_busy   = 1'b0;
                nxt_state  = BX_IDLE;
            end
            default: begin
                nxt_state = BX_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
        // Frozen cycles must not write the array either
        if (!ce) begin
            memWrEn = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Array contents survive reset; preload them before use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff            <= BX_IDLE;
            op_ff               <= NO_OP;
            addr_ff             <= ADDR_ZERO;
            dest_ff             <= DEST_ACC;
            acc_ff              <= DATA_ZERO;
            result_ff           <= DATA_ZERO;
            carryFlag_ff        <= 1'b0;
            half_borrow_flag_ff <= 1'b0;
            zeroFlag_ff         <= 1'b0;
            busy_ff             <= 1'b0;
            done_ff             <= 1'b0;
        end else if (ce) begin
            state_ff            <= nxt_state;
            op_ff               <= nxt_op;
            addr_ff             <= nxt_addr;
            dest_ff             <= nxt_dest;
            acc_ff              <= nxt_acc;
            result_ff           <= nxt_result;
            carryFlag_ff        <= nxt_carry;
            half_borrow_flag_ff <= nxt_half;
            zeroFlag_ff         <= nxt_zero;
            busy_ff             <= nxt_busy;
            done_ff             <= nxt_done;
        end
    end

endmodule

// File: logic/bxalu_file_mem.sv
// Purpose: File register array, one write port, registered read
// Assumes: Synchronous active-high reset clears only the read register
// Notes:   Array contents are not reset
`timescale 1ns/1ps
module bxalu_file_mem
    import bxalu_pkg::*;
(
    // Clock and control
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    // Write port
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    // Read port
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData_ff
);

    logic [DATA_W-1:0] memArray [DEPTH];
    logic [DATA_W-1:0] nxt_rdData;

    always_comb begin
        nxt_rdData = memArray[rdAddr];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdData_ff <= DATA_ZERO;
        end else if (ce) begin
            rdData_ff <= nxt_rdData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && wrEn) begin
            memArray[wrAddr] <= wrData;
        end
    end

endmodule

// File: logic/bxalu_pkg.sv
// Purpose: Shared constants and types for the byte ALU slice
// Assumes: 8-bit data path, 7-bit file register address
// Notes:   Opcode values are local encodings of this block
package bxalu_pkg;

    localparam int unsigned DATA_W  = 8;
    localparam int unsigned ADDR_W  = 7;
    localparam int unsigned NIB_W   = 4;
    localparam int unsigned DEPTH   = 128;
    localparam int unsigned OP_W    = 3;

    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
    localparam logic              DEST_ACC  = 1'b0;
    localparam logic              DEST_REG  = 1'b1;

    typedef logic [OP_W-1:0] bxalu_op_t;
    localparam bxalu_op_t literal_minus_acc_op = 3'h1;
    localparam bxalu_op_t literal_xor_acc_op   = 3'h2;
    localparam bxalu_op_t reg_minus_acc_op     = 3'h3;
    localparam bxalu_op_t reg_xor_acc_op       = 3'h4;
    localparam bxalu_op_t nibble_exchange_op   = 3'h5;
    localparam bxalu_op_t NO_OP                = 3'h0;

    // Sequence idle -> fetch -> exec -> idle; one bit per step except exec -> idle, which flips both
    typedef enum logic [1:0] {
        BX_IDLE  = 2'b00,
        BX_FETCH = 2'b01,
        BX_EXEC  = 2'b11
    } bxalu_state_e;

endpackage

// File: testbench/bxalu_core_asserts.sv
// Purpose: Port assertions for the byte ALU slice
// Assumes: ce drops only while no operation is in flight
// Notes:   File register contents are not visible here
`timescale 1ns/1ps
module bxalu_core_asserts
    import bxalu_pkg::*;
(
    // Clock and control
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              ce,
    // Request
    input wire logic              opValid,
    input wire logic [OP_W-1:0]   opCode,
    input wire logic [DATA_W-1:0] literal,
    input wire logic              destSel,
    // Results
    input wire logic [DATA_W-1:0] acc_ff,
    input wire logic              carryFlag_ff,
    input wire logic              half_borrow_flag_ff,
    input wire logic              zeroFlag_ff,
    input wire logic              busy_ff,
    input wire logic              done_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       go;
    logic       regGo;
    logic [9:0] subExp;
    logic [7:0] xr;
    assign go = ce && !busy_ff && opValid;
    assign regGo = go && opCode >= reg_minus_acc_op && opCode <= nibble_exchange_op;
    assign subExp = {literal >= acc_ff, literal[3:0] >= acc_ff[3:0], literal - acc_ff};
    assign xr = literal ^ acc_ff;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_LIT_SUB: assert property (
        go && opCode == literal_minus_acc_op |=> done_ff && zeroFlag_ff == (acc_ff == 8'h00)
        && {carryFlag_ff, half_borrow_flag_ff, acc_ff} == $past(subExp))
        else $error("literal subtract result or flags wrong");
    AST_LIT_XOR: assert property (
        go && opCode == literal_xor_acc_op |=> acc_ff == $past(xr)
        && zeroFlag_ff == (acc_ff == 8'h00) && $stable({carryFlag_ff, half_borrow_flag_ff}))
        else $error("literal xor result or flags wrong");
    AST_REG_TIMING: assert property (
        regGo |=> busy_ff ##1 busy_ff ##1 (done_ff && !busy_ff))
        else $error("register op timing wrong");
    AST_REG_ZERO: assert property (
        regGo && !destSel && opCode != nibble_exchange_op |=> ##2 zeroFlag_ff == (acc_ff == 8'h00))
        else $error("zero flag does not match result");
    AST_XOR_FLAGS: assert property (
        go && opCode == reg_xor_acc_op |=> $stable({carryFlag_ff, half_borrow_flag_ff})[*3])
        else $error("register xor touched carry flags");
    AST_SWAP_FLAGS: assert property (
        go && opCode == nibble_exchange_op |=> $stable({carryFlag_ff, half_borrow_flag_ff,
        zeroFlag_ff})[*3])
        else $error("swap changed a flag");
    AST_DEST_REG: assert property (
        regGo && destSel |=> $stable(acc_ff)[*3])
        else $error("register destination changed accumulator");
    cover property (go && opCode == literal_minus_acc_op);
    cover property (regGo && destSel);
    cover property (go && opCode == nibble_exchange_op);
endmodule

bind bxalu_core bxalu_core_asserts chk (.clk_sys, .rst, .ce, .opValid, .opCode, .literal,
    .destSel, .acc_ff, .carryFlag_ff, .half_borrow_flag_ff, .zeroFlag_ff, .busy_ff, .done_ff);

// File: testbench/byte_alu_sub_xor_swap_tb.sv
// Purpose: Self-checking bench for the byte ALU slice
// Assumes: ce dropped only in its own scenario; file registers preloaded
// Notes:   File registers read back through xor with a zero accumulator
`timescale 1ns/1ps
module byte_alu_sub_xor_swap_tb
    import bxalu_pkg::*;
;
    logic       clk_sys, rst, ce, opValid, destSel, accLoad, regLoad;
    logic [2:0] opCode;
    logic [7:0] literal, accLoadData, regLoadData, acc_ff, result_ff;
    logic [6:0] regAddr, regLoadAddr;
    logic       carryFlag_ff, half_borrow_flag_ff, zeroFlag_ff, busy_ff, done_ff;
    int         errors = 0;
    int         checked = 0;
    bxalu_core uut (.clk_sys, .rst, .ce, .opValid, .opCode, .literal, .regAddr, .destSel,
        .accLoad, .accLoadData, .regLoad, .regLoadAddr, .regLoadData, .acc_ff, .result_ff,
        .carryFlag_ff, .half_borrow_flag_ff, .zeroFlag_ff, .busy_ff, .done_ff);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] flags();
        return {5'h00, carryFlag_ff, half_borrow_flag_ff, zeroFlag_ff};
    endfunction
    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic load(input logic toReg, input logic [6:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        accLoad <= !toReg;
        regLoad <= toReg;
        accLoadData <= d;
        regLoadAddr <= ad;
        regLoadData <= d;
        @(posedge clk_sys);
        accLoad <= 1'b0;
        regLoad <= 1'b0;
    endtask
    task automatic run(input logic [2:0] op, input logic [7:0] k, input logic [6:0] ad,
                       input logic d);
        int n;
        @(posedge clk_sys);
        opValid <= 1'b1;
        opCode <= op;
        literal <= k;
        regAddr <= ad;
        destSel <= d;
        @(posedge clk_sys);
        opValid <= 1'b0;
        #1;
        n = 0;
        // Bounded wait: a lost done must not hang the run
        while (done_ff !== 1'b1) begin
            n++;
            if (n > 8) begin
                errors++;
                tally_and_finish();
            end
            @(posedge clk_sys);
            #1;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_lit();
        logic [7:0] a[3] = '{8'h05, 8'h01, 8'h42};
        logic [7:0] k[3] = '{8'h03, 8'h10, 8'h42};
        logic [7:0] e;
        for (int i = 0; i < 3; i++) begin
            load(1'b0, 7'h00, a[i]);
            run(literal_minus_acc_op, k[i], 7'h00, 1'b0);
            e = k[i] - a[i];
            check(e, acc_ff);
            check(e, result_ff);
            check({5'h00, k[i] >= a[i], k[i][3:0] >= a[i][3:0], e == 8'h00}, flags());
        end
        load(1'b0, 7'h00, 8'ha5);
        run(literal_xor_acc_op, 8'h5a, 7'h00, 1'b0);
        check(8'hff, acc_ff);
        check(8'h06, flags());
        run(literal_xor_acc_op, 8'hff, 7'h00, 1'b0);
        check(8'h07, flags());
        $display("test literal ops done");
    endtask
    task automatic t_reg();
        load(1'b1, 7'h7f, 8'h3c);
        load(1'b1, 7'h00, 8'hc3);
        load(1'b0, 7'h00, 8'h1d);
        run(reg_minus_acc_op, 8'h00, 7'h7f, 1'b1);
        check(8'h1d, acc_ff);
        check(8'h1f, result_ff);
        check(8'h04, flags());
        load(1'b0, 7'h00, 8'h00);
        run(reg_xor_acc_op, 8'h00, 7'h7f, 1'b0);
        check(8'h1f, acc_ff);
        check(8'h04, flags());
        load(1'b0, 7'h00, 8'hc3);
        run(reg_minus_acc_op, 8'h00, 7'h00, 1'b0);
        check(8'h00, acc_ff);
        check(8'h07, flags());
        $display("test register ops done");
    endtask
    task automatic t_swap();
        run(nibble_exchange_op, 8'h00, 7'h00, 1'b0);
        check(8'h3c, acc_ff);
        check(8'h07, flags());
        load(1'b0, 7'h00, 8'h00);
        run(nibble_exchange_op, 8'h00, 7'h00, 1'b1);
        check(8'h00, acc_ff);
        run(reg_xor_acc_op, 8'h00, 7'h00, 1'b0);
        check(8'h3c, acc_ff);
        $display("test swap done");
    endtask
    // Clock enable low must hold off both a request and a preload
    task automatic t_hold();
        load(1'b0, 7'h00, 8'h5a);
        @(posedge clk_sys);
        ce <= 1'b0;
        opValid <= 1'b1;
        opCode <= literal_xor_acc_op;
        literal <= 8'hff;
        accLoad <= 1'b1;
        accLoadData <= 8'h00;
        repeat (3) @(posedge clk_sys);
        #1;
        check(8'h5a, acc_ff);
        check(8'h00, {7'h00, done_ff});
        @(posedge clk_sys);
        opValid <= 1'b0;
        accLoad <= 1'b0;
        ce <= 1'b1;
        @(posedge clk_sys);
        #1;
        check(8'h5a, acc_ff);
        $display("test clock enable hold done");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, ce} = 2'b11;
        {opValid, destSel, accLoad, regLoad, opCode} = 7'h00;
        {literal, accLoadData, regLoadData} = 24'h000000;
        {regAddr, regLoadAddr} = 14'h0000;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(8'h00, acc_ff);
        check(8'h00, flags());
        t_lit();
        t_reg();
        t_swap();
        t_hold();
        tally_and_finish();
    end
endmodule
